// *** dv/sar_adc_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module sar_adc_props
	import sar_adc_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Register port
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regRdata,
	// Power state, front end, interrupt
	input wire logic       haltMode,
	input wire logic [2:0] muxChannel,
	input wire logic       sampleHold,
	input wire logic       doneIrq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire csrWr = regWrite && regAddr == OFS_CONTROL_STATUS;
	a_low_upper_zero: assert property (
		$past(regRead && regAddr == OFS_RESULT_LOW) |-> regRdata[7:2] == 6'h00
	) else $error("low byte upper bits not zero");
	a_irq_tracks_flag: assert property (
		$past(regRead && regAddr == OFS_CONTROL_STATUS)
		|-> $past(doneIrq) == (regRdata[7] && regRdata[4])
	) else $error("irq disagrees with flag and enable");
	a_high_read_clears: assert property (
		regRead && regAddr == OFS_RESULT_HIGH && sampleHold |=> !doneIrq
	) else $error("high read left flag set");
	a_new_channel_starts: assert property (
		csrWr && regWdata[5] && !haltMode && regWdata[2:0] != muxChannel
		|-> ##[1:3] sampleHold
	) else $error("no sampling after channel change");
	a_channel_follows: assert property (
		csrWr |-> ##2 muxChannel == $past(regWdata[2:0], 2)
	) else $error("mux channel not from select field");
	a_off_stops: assert property (
		csrWr && !regWdata[5] |=> ##2 !sampleHold [*4]
	) else $error("sampling while converter off");
	a_halt_idle: assert property (
		haltMode [*3] |-> !sampleHold
	) else $error("sampling during halt");
	a_sample_length: assert property (
		$rose(sampleHold) ##1 (!regWrite && !haltMode) [*4] |-> sampleHold
	) else $error("sampling phase too short");
	c_done: cover property ($rose(doneIrq));
	c_start: cover property ($rose(sampleHold));
	c_low_read: cover property (regRead && regAddr == OFS_RESULT_LOW);
endmodule : sar_adc_props
bind sar_adc_sequencer sar_adc_props sar_adc_props_i (.ref_clk, .rst_n,
	.regAddr, .regWdata, .regWrite, .regRead, .regRdata, .haltMode,
	.muxChannel, .sampleHold, .doneIrq);
`default_nettype wire

// *** dv/sar_adc_sequencer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer_tb;
	import sar_adc_pkg::*;
	logic       ref_clk = 0;
	logic       rst_n = 0;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWdata = 8'h00;
	logic       regWrite = 0;
	logic       regRead = 0;
	logic       haltMode = 0;
	logic       overHigh = 0;
	logic       underLow = 0;
	logic [7:0] regRdata;
	logic [2:0] muxChannel;
	logic [9:0] dacCode;
	logic       compAbove;
	logic       doneIrq;
	int         err_total = 0;
	int         n_tests = 0;
	always #20 ref_clk = ~ref_clk;
	sar_adc_sequencer sar_adc_sequencer_i (.ref_clk, .rst_n, .regAddr,
		.regWdata, .regWrite, .regRead, .regRdata, .haltMode, .muxChannel,
		.sampleHold(), .dacCode, .compAbove, .inputOverHigh(overHigh),
		.inputUnderLow(underLow), .doneIrq);
	sar_afe_model sar_afe_model_i (.muxChannel, .dacCode, .compAbove);
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1;
		@(posedge ref_clk);
		regWrite <= 0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rdc(input logic [1:0] a, input logic [7:0] e, input string nm);
		regAddr <= a;
		regRead <= 1;
		@(posedge ref_clk);
		regRead <= 0;
		#1 chk(nm, e, regRdata);
		@(posedge ref_clk);
	endtask : rdc
	// Bounded wait on the flag; irq enable is always set
	task automatic wdone();
		int i;
		for (i = 0; i < 500 && doneIrq !== 1'b1; i++)
			@(posedge ref_clk);
		if (i == 500) begin
			err_total++;
			wrap_up();
		end
	endtask : wdone
	task automatic t_single(input logic [7:0] c, input logic [9:0] e);
		wr(OFS_CONTROL_STATUS, c);
		wdone();
		rdc(OFS_CONTROL_STATUS, (c & 8'hDF) | 8'h80, "csr");
		rdc(OFS_RESULT_LOW, {6'h00, e[1:0]}, "low");
		rdc(OFS_RESULT_HIGH, e[9:2], "high");
		rdc(OFS_CONTROL_STATUS, c & 8'h5F, "csr");
	endtask : t_single
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1;
		@(posedge ref_clk);
		wr(OFS_CONTROL_STATUS, 8'h80);
		wr(OFS_RESULT_HIGH, 8'hFF);
		for (int a = 0; a < 4; a++)
			rdc(2'(a), 8'h00, "reset");
		for (int c = 1; c < 8; c++)
			t_single(8'h38 | 8'(c), {3'(c), 7'h55});
		t_single(8'h78, 10'h055);
		overHigh <= 1;
		t_single(8'h39, 10'h3FF);
		overHigh <= 0;
		underLow <= 1;
		t_single(8'h3A, 10'h000);
		underLow <= 0;
		wr(OFS_CONTROL_STATUS, 8'h3D);
		repeat (10) @(posedge ref_clk);
		t_single(8'h3E, 10'h355);
		wr(OFS_CONTROL_STATUS, 8'h33);
		wdone();
		rdc(OFS_RESULT_LOW, 8'h01, "low");
		overHigh <= 1;
		repeat (150) @(posedge ref_clk);
		rdc(OFS_RESULT_HIGH, 8'h75, "frozen");
		wdone();
		rdc(OFS_RESULT_LOW, 8'h03, "low");
		rdc(OFS_RESULT_HIGH, 8'hFF, "high");
		overHigh <= 0;
		wr(OFS_CONTROL_STATUS, 8'h13);
		rdc(OFS_CONTROL_STATUS, 8'h13, "off");
		repeat (100) @(posedge ref_clk);
		chk("irq", 8'h00, {7'h00, doneIrq});
		haltMode <= 1;
		wr(OFS_CONTROL_STATUS, 8'h3C);
		rdc(OFS_CONTROL_STATUS, 8'h3C, "halt");
		repeat (100) @(posedge ref_clk);
		chk("irq", 8'h00, {7'h00, doneIrq});
		haltMode <= 0;
		wdone();
		rdc(OFS_RESULT_HIGH, 8'h95, "high");
		wrap_up();
	end
endmodule : sar_adc_sequencer_tb
`default_nettype wire

// *** dv/sar_afe_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module sar_afe_model (
	// Design side
	input wire logic [2:0] muxChannel,
	input wire logic [9:0] dacCode,
	output logic           compAbove
);
	// Level per channel {channel,7'h55} tells a wrong channel apart
	assign compAbove = {muxChannel, 7'h55} >= dacCode;
endmodule : sar_afe_model
`default_nettype wire

// *** verilog/sar_adc_pkg.sv ***
package sar_adc_pkg;

	localparam logic [1:0] OFS_CONTROL_STATUS = 2'h0;
	localparam logic [1:0] OFS_RESULT_HIGH    = 2'h1;
	localparam logic [1:0] OFS_RESULT_LOW     = 2'h2;

	localparam int BIT_DONE      = 7;
	localparam int BIT_SLOW_CLK  = 6;
	localparam int BIT_ON        = 5;
	localparam int BIT_IRQ_EN    = 4;
	localparam int BIT_SINGLE    = 3;

	localparam logic [7:0] CSR_RESET    = 8'h00;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [9:0] RESULT_FULL  = 10'h3FF;

	localparam int SAMPLE_TICKS = 3;
	localparam int RESULT_BITS  = 10;

	typedef struct packed {
		logic       done;
		logic       slowClk;
		logic       on;
		logic       irqEnable;
		logic       single;
		logic [2:0] channel;
	} csr_t;

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_SAMPLE = 4'b0010,
		S_BITS   = 4'b0100,
		S_FINISH = 4'b1000
	} conv_state_t;

endpackage : sar_adc_pkg

// *** verilog/sar_adc_sequencer.sv ***
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer
	import sar_adc_pkg::*;
#(
	parameter int RES_BITS = RESULT_BITS
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [1:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdata,
	// Processor power state
	input  wire logic       haltMode,
	// Analog front end
	output logic      [2:0] muxChannel,
	output logic            sampleHold,
	output logic      [9:0] dacCode,
	input  wire logic       compAbove,
	input  wire logic       inputOverHigh,
	input  wire logic       inputUnderLow,
	// Interrupt request
	output logic            doneIrq
);

	////////////////////////////////////////////////////////////////////////
	csr_t        csr;
	conv_state_t state;
	logic [1:0]  divCount;
	logic        tick;
	logic [3:0]  stepCount;
	logic [9:0]  trial;
	logic [9:0]  result;
	logic        frozen;
	logic        finish;
	logic        chanChange;
	logic        startReq;
	logic [1:0]  compSync;
	logic [1:0]  overSync;
	logic [1:0]  underSync;
	logic        readHigh;
	logic        readLow;
	logic        writeCsr;
	logic [9:0]  next_result;
	logic        settle;

	assign writeCsr   = regWrite && regAddr == OFS_CONTROL_STATUS;
	assign readHigh   = regRead && regAddr == OFS_RESULT_HIGH;
	assign readLow    = regRead && regAddr == OFS_RESULT_LOW;
	assign chanChange = writeCsr && regWdata[2:0] != csr.channel;
	assign finish     = state == S_FINISH;

	// Front-end flags are analog and asynchronous to this clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			compSync  <= 2'h0;
			overSync  <= 2'h0;
			underSync <= 2'h0;
		end else begin
			compSync  <= {compSync[0], compAbove};
			overSync  <= {overSync[0], inputOverHigh};
			underSync <= {underSync[0], inputUnderLow};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Converter clock enable
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !csr.on || haltMode)
			divCount <= 2'h0;
		else
			divCount <= divCount + 2'h1;
	end

	always_comb begin
		if (csr.slowClk)
			tick = divCount == 2'h3;
		else
			tick = divCount[0];
	end

	////////////////////////////////////////////////////////////////////////
	// Control/status register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			csr <= csr_t'(CSR_RESET);
		end else begin
			if (writeCsr) begin
				csr.slowClk   <= regWdata[BIT_SLOW_CLK];
				csr.on        <= regWdata[BIT_ON];
				csr.irqEnable <= regWdata[BIT_IRQ_EN];
				csr.single    <= regWdata[BIT_SINGLE];
				csr.channel   <= regWdata[2:0];
			end
			// Hardware clear loses to a software set in the same cycle
			if (finish && csr.single && !(writeCsr && regWdata[BIT_ON]))
				csr.on <= 1'b0;
			// Set wins over the read clear
			if (finish)
				csr.done <= 1'b1;
			else if (readHigh || startReq)
				csr.done <= 1'b0;
		end
	end

	// New conversion start: on bit written while off or idle, or with a channel change
	assign startReq = writeCsr && regWdata[BIT_ON]
		&& (!csr.on || chanChange || state == S_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Successive approximation sequencer
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state     <= S_IDLE;
			stepCount <= 4'h0;
			trial     <= RESULT_RESET;
			settle    <= 1'b0;
		end else if (!csr.on || haltMode) begin
			state     <= S_IDLE;
			stepCount <= 4'h0;
			settle    <= 1'b0;
		end else if (startReq) begin
			state     <= S_SAMPLE;
			stepCount <= 4'h0;
			trial     <= RESULT_RESET;
			settle    <= 1'b0;
		end else begin
			case (state)
				// On while idle means a conversion is owed in either mode
				S_IDLE: begin
					state     <= S_SAMPLE;
					stepCount <= 4'h0;
				end
				S_SAMPLE: begin
					if (tick) begin
						if (stepCount == 4'(SAMPLE_TICKS - 1)) begin
							state     <= S_BITS;
							stepCount <= 4'(RES_BITS - 1);
							trial     <= 10'h200;
							settle    <= 1'b0;
						end else begin
							stepCount <= stepCount + 4'h1;
						end
					end
				end
				S_BITS: begin
					// Two ticks per bit: code register plus sync need four clocks
					if (tick) begin
						settle <= !settle;
						if (settle) begin
							if (!compSync[1])
								trial[stepCount] <= 1'b0;
							if (stepCount == 4'h0) begin
								state <= S_FINISH;
							end else begin
								trial[stepCount - 4'h1] <= 1'b1;
								stepCount <= stepCount - 4'h1;
							end
						end
					end
				end
				S_FINISH: begin
					if (csr.single)
						state <= S_IDLE;
					else
						state <= S_SAMPLE;
					stepCount <= 4'h0;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result and lock
	always_comb begin
		if (overSync[1])
			next_result = RESULT_FULL;
		else if (underSync[1])
			next_result = RESULT_RESET;
		else
			next_result = trial;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			frozen <= 1'b0;
		else if (readHigh || !csr.on)
			frozen <= 1'b0;
		else if (readLow)
			frozen <= 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			result <= RESULT_RESET;
		else if (finish && !frozen)
			result <= next_result;
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			regRdata <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				OFS_CONTROL_STATUS: regRdata <= csr;
				OFS_RESULT_HIGH:    regRdata <= result[9:2];
				OFS_RESULT_LOW:     regRdata <= {6'h00, result[1:0]};
				default:            regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			muxChannel <= 3'h0;
			sampleHold <= 1'b0;
			dacCode    <= RESULT_RESET;
		end else begin
			muxChannel <= csr.channel;
			sampleHold <= state == S_SAMPLE;
			dacCode    <= trial;
		end
	end

	assign doneIrq = csr.done && csr.irqEnable;

endmodule : sar_adc_sequencer
`default_nettype wire
